// file: logic/single_wire_pkg.sv
/*
  shared types and constants for the single-wire bus master: timing in ns,
  derived cycle counts at 125 MHz, command and response carriers, and the
  command bytes and page layout the user side sequences.
  assumes a 125 MHz system clock and an external pull-up on the line.
*/
package single_wire_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 8;

  // line timing, ns
  localparam int T_RST_LOW_NS = 480000;
  localparam int T_RST_HIGH_NS = 480000;
  localparam int T_SLOT_NS = 60000;
  localparam int T_REC_NS = 1000;
  localparam int T_W1_LOW_NS = 6000;
  localparam int T_RD_LOW_NS = 1000;
  localparam int T_RD_SAMPLE_NS = 13000;

  // least times round up, latest times round down
  localparam int RST_LOW_CYC_DEF = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HIGH_CYC_DEF = (T_RST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CYC_DEF = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] REC_CYC = 17'((T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [16:0] W1_LOW_CYC = 17'((T_W1_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [16:0] RD_LOW_CYC = 17'((T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [16:0] RD_SAMPLE_CYC = 17'(T_RD_SAMPLE_NS / CLK_PERIOD_NS);

  // bits in a byte, response buffer depth
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ONE_BIT = 4'h1;
  localparam logic [1:0] RSP_DEPTH = 2'h2;

  // command bytes for the user-side sequencer
  localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;
  localparam logic [7:0] CMD_CONVERT_TEMP = 8'h44;
  localparam logic [7:0] CMD_CONVERT_VOLT = 8'hb4;
  localparam logic [7:0] CMD_RECALL_PAGE = 8'hb8;
  localparam logic [7:0] READ_SCRATCHPAD_CMD = 8'hbe;

  // scratchpad layout: eight data bytes then a crc
  localparam int SCRATCH_READ_BYTES = 9;
  localparam logic [7:0] PAGE_MEASURE = 8'h00;
  localparam logic [7:0] PAGE_ACCUM = 8'h01;
  localparam logic [7:0] PAGE_TOTALS = 8'h07;
  localparam int ACCUM_BYTE = 4;
  localparam int CHARGE_TOTAL_BYTE = 4;
  localparam int DISCHARGE_TOTAL_BYTE = 6;

  typedef enum logic [1:0] {
    OP_RESET,
    OP_WRITE_BYTE,
    OP_READ_BYTE,
    OP_READ_BIT
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    op_t op;
    logic [7:0] data;
    logic presence;
    logic refused;
  } rsp_t;

endpackage : single_wire_pkg

// file: logic/single_wire_master.sv
/*
  single-wire bus master: reset/presence, write slots and read slots on an
  open-drain line, one byte or one bit per command, one response per command
  through a two-entry buffer.
  assumes an external pull-up on the line and a single device on the bus.
*/
// What this block does; the last three are left to the user-side sequencer
// - only presence comes from device; master starts rest
// - initialize with reset and presence before commands
// - master releases line after reset, then listens
// - master opens each write slot pulling line low
// - write slots last 60 us, 1 us recovery
// - write one: line high again within 15 us
// - write zero: line held low whole slot
// - read slot opens with at least 1 us low
// - master releases and samples by 15 us
// - read slots last 60 us, 1 us recovery
// - short low time, sample late in window
// - convert temperature: skip-rom then 44h, poll
// - convert voltage: skip-rom then b4h, poll
// - recall page b8h plus page before reading
module single_wire_master
  import single_wire_pkg::*;
#(
  parameter logic [16:0] RST_LOW_CYC = 17'(RST_LOW_CYC_DEF),
  parameter logic [16:0] RST_HIGH_CYC = 17'(RST_HIGH_CYC_DEF),
  parameter logic [16:0] SLOT_CYC = 17'(SLOT_CYC_DEF)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_t cmd,
  // response port
  output logic rsp_valid,
  input wire logic rsp_ready,
  output rsp_t rsp,
  // open-drain line
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  // status
  output logic link_ready,
  output logic busy
);

  typedef enum logic [2:0] {IDLE, RST_LOW, RST_WAIT, SLOT, RECOVER, RESP} state_t;

  state_t state_ff, nxt_state;
  logic [16:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [3:0] bits_left_ff;
  op_t op_ff;
  logic refused_ff, init_ff, seen_high_ff, pres_ff;
  logic dq_s1_ff, dq_s2_ff, dq_s3_ff, dq_line_ff;

  // buffer
  rsp_t buf_mem_ff [2];
  logic wr_ptr_ff, rd_ptr_ff;
  logic [1:0] buf_cnt_ff;

  // decode
  logic cmd_accept, refuse, is_read, cur_bit, drive_low, sample_en, slot_end;
  logic rec_end, push, pop, buf_in_ready;
  logic [16:0] low_len;
  rsp_t push_rsp;

  function automatic logic op_reads(input op_t op);
    op_reads = (op == OP_READ_BYTE) || (op == OP_READ_BIT);
  endfunction : op_reads

  assign cmd_ready = (state_ff == IDLE);
  assign cmd_accept = cmd_valid && cmd_ready;
  assign refuse = (cmd.op != OP_RESET) && !init_ff;
  assign is_read = op_reads(op_ff);
  assign cur_bit = shift_ff[0];
  // read low kept at the minimum so the device has the most time to answer
  assign low_len = is_read ? RD_LOW_CYC : (cur_bit ? W1_LOW_CYC : SLOT_CYC);
  assign drive_low = (state_ff == RST_LOW) || ((state_ff == SLOT) && (cnt_ff < low_len));
  assign sample_en = (state_ff == SLOT) && is_read && (cnt_ff == RD_SAMPLE_CYC);
  assign slot_end = (state_ff == SLOT) && (cnt_ff == SLOT_CYC - 17'h1);
  assign rec_end = (state_ff == RECOVER) && (cnt_ff == REC_CYC - 17'h1);
  assign buf_in_ready = (buf_cnt_ff != RSP_DEPTH);
  assign push = (state_ff == RESP) && buf_in_ready;
  assign pop = rsp_valid && rsp_ready;

  assign dq_out = 1'b0;
  assign dq_oe = drive_low;
  assign link_ready = init_ff;
  assign busy = (state_ff != IDLE);

  // single-bit polls land in bit 0; writes and resets return zero data
  assign push_rsp.op = op_ff;
  assign push_rsp.data = refused_ff ? 8'h00 :
                         (op_ff == OP_READ_BIT) ? {7'h00, shift_ff[7]} :
                         (op_ff == OP_READ_BYTE) ? shift_ff : 8'h00;
  assign push_rsp.presence = pres_ff;
  assign push_rsp.refused = refused_ff;

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IDLE: begin
        if (cmd_accept) begin
          if (refuse) begin
            nxt_state = RESP;
          end else if (cmd.op == OP_RESET) begin
            nxt_state = RST_LOW;
          end else begin
            nxt_state = SLOT;
          end
        end
      end
      RST_LOW: begin
        if (cnt_ff == RST_LOW_CYC - 17'h1) begin
          nxt_state = RST_WAIT;
        end
      end
      RST_WAIT: begin
        if (cnt_ff == RST_HIGH_CYC - 17'h1) begin
          nxt_state = RESP;
        end
      end
      SLOT: begin
        if (slot_end) begin
          nxt_state = RECOVER;
        end
      end
      RECOVER: begin
        if (rec_end) begin
          nxt_state = (bits_left_ff == 4'h0) ? RESP : SLOT;
        end
      end
      RESP: begin
        if (push) begin
          nxt_state = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff <= IDLE;
      cnt_ff <= 17'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (nxt_state != state_ff) ? 17'h0 : cnt_ff + 17'h1;
    end
  end

  // line input: three stages, a level counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dq_s1_ff <= 1'b1;
      dq_s2_ff <= 1'b1;
      dq_s3_ff <= 1'b1;
      dq_line_ff <= 1'b1;
    end else begin
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
      if (dq_s2_ff == dq_s3_ff) begin
        dq_line_ff <= dq_s3_ff;
      end
    end
  end

  // command capture and bit shifting
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_ff <= 8'h00;
      bits_left_ff <= 4'h0;
      op_ff <= OP_RESET;
      refused_ff <= 1'b0;
    end else if (cmd_accept) begin
      shift_ff <= (cmd.op == OP_WRITE_BYTE) ? cmd.data : 8'h00;
      bits_left_ff <= (cmd.op == OP_READ_BIT) ? ONE_BIT : BYTE_BITS;
      op_ff <= cmd.op;
      refused_ff <= refuse;
    end else if (sample_en) begin
      shift_ff <= {dq_line_ff, shift_ff[7:1]};
    end else if (slot_end) begin
      if (!is_read) begin
        shift_ff <= {1'b0, shift_ff[7:1]};
      end
      bits_left_ff <= bits_left_ff - 4'h1;
    end
  end

  // presence: a low after the line has come back high
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      seen_high_ff <= 1'b0;
      pres_ff <= 1'b0;
      init_ff <= 1'b0;
    end else if (state_ff == RST_LOW) begin
      seen_high_ff <= 1'b0;
      pres_ff <= 1'b0;
      init_ff <= 1'b0;
    end else if (state_ff == RST_WAIT) begin
      if (dq_line_ff) begin
        seen_high_ff <= 1'b1;
      end else if (seen_high_ff) begin
        pres_ff <= 1'b1;
      end
      if (nxt_state == RESP) begin
        init_ff <= pres_ff;
      end
    end
  end

  // two-entry response buffer; a full buffer holds the engine in RESP
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= !wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= !rd_ptr_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      buf_mem_ff[0] <= '0;
      buf_mem_ff[1] <= '0;
    end else if (push) begin
      buf_mem_ff[wr_ptr_ff] <= push_rsp;
    end
  end

  assign rsp_valid = (buf_cnt_ff != 2'h0);
  assign rsp = buf_mem_ff[rd_ptr_ff];

  // checks
  rst_low_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_ff == RST_LOW) && (nxt_state == RST_WAIT) |-> cnt_ff == RST_LOW_CYC - 17'h1)
    else $error("reset pulse ended early");

  rst_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_ff == RST_WAIT) |-> !dq_oe)
    else $error("line driven while waiting for presence");

  drive_owner_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    dq_oe |-> (state_ff == RST_LOW) || (state_ff == SLOT))
    else $error("line driven outside reset or slot");

  slot_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_ff == SLOT) && (nxt_state == RECOVER) |-> cnt_ff == SLOT_CYC - 17'h1)
    else $error("slot shorter than minimum");

  recovery_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(state_ff == RECOVER) |-> !dq_oe [*8])
    else $error("line driven during recovery");

  write_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_ff == SLOT) && !is_read && cur_bit && (cnt_ff == W1_LOW_CYC) |-> !dq_oe)
    else $error("write one held low too long");

  write_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_ff == SLOT) && !is_read && !cur_bit |-> dq_oe)
    else $error("write zero released early");

  read_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(state_ff == SLOT) && is_read |-> dq_oe [*8])
    else $error("read slot low phase too short");

  read_sample_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sample_en |-> !dq_oe && (cnt_ff == RD_SAMPLE_CYC) && !$past(dq_oe))
    else $error("read sampled while driving or off time");

  refuse_uninit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_accept && (cmd.op != OP_RESET) && !init_ff |=> (state_ff == RESP) && refused_ff)
    else $error("command before initialization reached the line");

  lsb_first_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_accept && (cmd.op == OP_WRITE_BYTE) && init_ff |=> shift_ff == $past(cmd.data))
    else $error("write byte not loaded for lsb-first shifting");

  reset_presence_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    push && (op_ff == OP_RESET) && pres_ff);
  write_byte_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    push && (op_ff == OP_WRITE_BYTE) && !refused_ff);
  read_byte_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    push && (op_ff == OP_READ_BYTE) && !refused_ff);
  buffer_stall_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    (state_ff == RESP) && !buf_in_ready);

endmodule : single_wire_master

// file: tb/batt_monitor_model.sv
/*
  device model on the single-wire line: presence, write sampling, polling,
  page recall and scratchpad read, timed in clk_sys cycles.
  assumes the bench resolves the open-drain wire; timings are scaled down.
*/
module batt_monitor_model #(
  parameter int RST_DET = 3000,
  parameter int PDH = 200,
  parameter int PDL = 400,
  parameter int SAMPLE = 1000,
  parameter int HOLD = 1700,
  parameter int POLLS = 3
) (
  // clock
  input wire logic clk_sys,
  // line level and device pull
  input wire logic line,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line_q = 1'b1;
  logic tx = 1'b0;
  logic poll = 1'b0;
  logic rd_slot = 1'b0;  // slot opened while answering
  logic [7:0] rx_sh, func, cur, b;
  logic [7:0] mem [8][8];
  logic [7:0] scratch [8];
  int low_cnt = 0, pres_cnt = 0, slot_cnt = 0, nbits = 0, nbytes = 0, conv = 0, idx = 0;

  function automatic logic [7:0] tx_byte(int k);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) c ^= scratch[i];
    if (k < 8) return scratch[k];
    return (k == 8) ? c : 8'hff;  // xor stands in for the crc
  endfunction : tx_byte

  initial begin
    pull_low = 1'b0;
    foreach (mem[p, q]) mem[p][q] = 8'(p * 16 + q) ^ 8'h5a;
    foreach (scratch[i]) scratch[i] = 8'hff;
  end

  always @(posedge clk_sys) begin
    line_q <= line;
    low_cnt <= line ? 0 : low_cnt + 1;
    if (line && !line_q && low_cnt >= RST_DET) begin  // long low restarts
      pres_cnt <= 1;
      nbits <= 0;
      nbytes <= 0;
      tx <= 1'b0;
      pull_low <= 1'b0;
    end else if (pres_cnt != 0) begin  // wait, then presence low
      pres_cnt <= (pres_cnt == PDH + PDL) ? 0 : pres_cnt + 1;
      pull_low <= pres_cnt >= PDH && pres_cnt < PDH + PDL;
    end else if (!line && line_q && slot_cnt == 0) begin  // slot opened by master
      slot_cnt <= 1;
      rd_slot <= tx;
      cur = tx_byte(idx / 8);
      if (tx) pull_low <= poll ? conv != 0 : !cur[idx % 8];
    end else if (slot_cnt != 0) begin
      slot_cnt <= (slot_cnt == HOLD) ? 0 : slot_cnt + 1;
      b = {line, rx_sh[7:1]};
      if (slot_cnt == SAMPLE && !tx) begin  // lsb first
        rx_sh <= b;
        nbits <= (nbits == 7) ? 0 : nbits + 1;
        if (nbits == 7) nbytes <= nbytes + 1;
        if (nbits == 7 && nbytes == 1) func <= b;
        if (nbits == 7 && nbytes == 1 && (b == 8'h44 || b == 8'hb4)) begin
          tx <= 1'b1;
          poll <= 1'b1;
          conv <= POLLS;
        end
        if (nbits == 7 && nbytes == 2 && func == 8'hb8) scratch <= mem[b[2:0]];
        if (nbits == 7 && nbytes == 2 && func == 8'hbe) begin
          tx <= 1'b1;
          poll <= 1'b0;
          idx <= 0;
        end
      end
      if (slot_cnt == HOLD && rd_slot) begin  // only answer slots advance poll and bit counts
        pull_low <= 1'b0;
        conv <= (conv != 0) ? conv - 1 : 0;
        idx <= idx + 1;
      end
    end
  end
endmodule : batt_monitor_model

// file: tb/test_single_wire_master.sv
/*
  self-checking bench for the single-wire master against the device model.
  assumes shortened reset and slot counts and a pull-up on the wire.
*/
module test_single_wire_master;
  import single_wire_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_LOW = 4000;
  localparam int SLOT = 1800;
  localparam int POLLS = 3;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic rsp_ready = 1'b0;
  cmd_t cmd = '0;
  logic cmd_ready, rsp_valid, dq_oe, dq_out, link_ready, busy, pull_low, line;
  rsp_t rsp;
  logic oe_seen = 1'b0;
  int run = 0, last_low = 0, n_errors = 0, n_compared = 0;
  assign line = !((dq_oe && !dq_out) || pull_low);  // pull-up unless someone pulls

  single_wire_master #(.RST_LOW_CYC(17'(RST_LOW)), .RST_HIGH_CYC(17'h004b0),
    .SLOT_CYC(17'(SLOT))) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe),
    .link_ready(link_ready), .busy(busy));
  batt_monitor_model #(.POLLS(POLLS)) i_model (.clk_sys(clk_sys), .line(line),
    .pull_low(pull_low));

  always @(posedge clk_sys) begin  // width of each master low pulse
    run <= dq_oe ? run + 1 : 0;
    if (!dq_oe && run != 0) last_low <= run;
    if (dq_oe) oe_seen <= 1'b1;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic send(op_t op, logic [7:0] d);
    int n;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd = {op, d};
    for (n = 0; cmd_ready !== 1'b1 && n < 20000; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : send

  task automatic pop(output rsp_t r);
    int n;
    @(negedge clk_sys);
    for (n = 0; rsp_valid !== 1'b1 && n < 40000; n++) @(negedge clk_sys);
    r = rsp;
    rsp_ready = 1'b1;
    @(negedge clk_sys);
    rsp_ready = 1'b0;
  endtask : pop

  task automatic xact(op_t op, logic [7:0] d, output rsp_t r);
    send(op, d);
    pop(r);
  endtask : xact

  task automatic wr(logic [7:0] d);
    rsp_t r;
    xact(OP_WRITE_BYTE, d, r);
  endtask : wr

  function automatic logic [7:0] mem_byte(logic [7:0] pg, int k);
    return 8'(pg * 16 + k) ^ 8'h5a;
  endfunction : mem_byte

  task automatic t_refused;
    rsp_t r;
    send(OP_WRITE_BYTE, 8'ha5);
    send(OP_READ_BYTE, 8'h00);
    send(OP_READ_BIT, 8'h00);
    repeat (10) @(negedge clk_sys);
    check("stall", {cmd_ready, rsp_valid, busy}, 3'b011);
    for (int i = 0; i < 3; i++) begin
      pop(r);
      check("refused", {r.op, r.data, r.refused}, {2'(i + 1), 8'h00, 1'b1});
    end
    check("line idle", {oe_seen, busy}, 2'b00);
    $display("test refused done");
  endtask : t_refused

  task automatic t_init;
    rsp_t r;
    xact(OP_RESET, 8'h00, r);
    check("presence", {r.presence, link_ready}, 2'b11);
    check("reset low", last_low, RST_LOW);
  endtask : t_init

  task automatic t_convert(logic [7:0] fn);
    rsp_t r;
    t_init;
    wr(CMD_SKIP_ROM);
    wr(fn);
    check("write low", last_low, fn[7] ? W1_LOW_CYC : SLOT);
    for (int i = 0; i <= POLLS; i++) begin
      xact(OP_READ_BIT, 8'h00, r);
      check("poll", r.data[0], i == POLLS);
    end
    check("read low", last_low, RD_LOW_CYC);
    $display("test convert %h done", fn);
  endtask : t_convert

  task automatic t_page(logic [7:0] pg, int nread);
    rsp_t r;
    logic [7:0] x;
    t_init;
    wr(CMD_SKIP_ROM);
    wr(CMD_RECALL_PAGE);
    wr(pg);
    t_init;
    wr(CMD_SKIP_ROM);
    wr(READ_SCRATCHPAD_CMD);
    wr(pg);
    x = 8'h00;
    for (int k = 0; k < nread; k++) begin
      xact(OP_READ_BYTE, 8'h00, r);
      check("page byte", r.data, k < 8 ? mem_byte(pg, k) : x);
      if (k < 8) x ^= mem_byte(pg, k);
    end
    $display("test page %h done", pg);
  endtask : t_page

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (700000) @(posedge clk_sys);
    n_errors++;
    $display("unexpected run length: expected below 700000 cycles, seen more");
    test_done();
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    t_refused();
    t_convert(CMD_CONVERT_TEMP);
    t_convert(CMD_CONVERT_VOLT);
    t_page(PAGE_ACCUM, ACCUM_BYTE + 1);
    t_page(PAGE_TOTALS, SCRATCH_READ_BYTES);
    test_done();
  end
endmodule : test_single_wire_master
